// [rtl/eiu_map.svh]
`ifndef EIU_MAP_SVH
`define EIU_MAP_SVH
// ------------------------------------------------------------
// register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define EIU_IDX_CTRL 8'hE6
`define EIU_IDX_EDGE 8'hF2
`define EIU_IDX_PEND 8'hF3
`define EIU_IDX_MASK 8'hF4
`define EIU_IDX_PAIR 8'hF5
`define EIU_IDX_VECT 8'hF6
`define EIU_IDX_HOLD 8'hF7
`define EIU_IDX_SRC 8'hF8
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define EIU_RST_CTRL 8'h87
`define EIU_RST_EDGE 8'h00
`define EIU_RST_PAIR 8'hFF
`define EIU_RST_VECT 8'h06
`define EIU_RST_SRC 8'hFF
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define EIU_CTRL_MFT 7
`define EIU_CTRL_TOPP 6
`define EIU_CTRL_TLI 5
`define EIU_CTRL_GIE 4
`define EIU_CTRL_MODE 3
`define EIU_VECT_POL 3
`define EIU_VECT_TSRC 2
`define EIU_VECT_A0S 1
`define EIU_VECT_WAIT 0
`define EIU_HOLD_LOCK 7
// ------------------------------------------------------------
// timing counts in cpu clocks, and the lowest priority level
// ------------------------------------------------------------
`define EIU_ARB_CYCLES 5
`define EIU_ENTRY_BASE 18
`define EIU_ENTRY_STACK 2
`define EIU_ENTRY_CSR 2
`define EIU_ENTRY_WFI 1
`define EIU_LOWEST 3'h7
`endif

// [rtl/eiu_pkg.sv]
package eiu_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } eiu_wb_req_t;
    typedef enum logic [1:0] {
        ENT_IDLE,
        ENT_HOLD,
        ENT_CYCLE
    } eiu_ent_t;
endpackage

// [rtl/eiu_top.sv]
`timescale 1ns/1ps
`include "eiu_map.svh"
module eiu_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire eiu_pkg::eiu_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] ext_pin_i,
    input wire logic nmi_pin_i,
    input wire logic [7:0] periph_evt_i,
    input wire logic wdg_eoc_i,
    input wire logic write_done_i,
    input wire logic instr_end_i,
    input wire logic iret_i,
    input wire logic ei_i,
    input wire logic di_i,
    input wire logic stack_in_rf_i,
    input wire logic csr_save_i,
    input wire logic wfi_i,
    output logic req_o,
    output logic req_top_o,
    output logic [2:0] req_level_o,
    output logic [7:0] vector_o,
    output logic service_start_o,
    output logic abort_o,
    output logic entry_done_o,
    output logic top_isr_o,
    output logic mft_enable_o,
    output logic wait_enable_o
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg, edge_reg, pend_reg, mask_reg, pair_reg;
    logic [7:0] vect_reg, src_reg;
    logic [6:0] hold_reg;
    logic lock_reg, top_pend_reg, top_active_reg;
    logic [2:0] arb_cnt_reg;
    logic [4:0] ent_cnt_reg;
    logic [7:0] idx;
    logic acc, wr;
    logic [7:0] wd;
    logic [7:0] rd_next;
    eiu_pkg::eiu_ent_t state_reg;

    assign idx = wb_i.adr[9:2];
    assign acc = wb_i.cyc & wb_i.stb & ~wb_ack_o;
    assign wr = acc & wb_i.we & wb_i.sel[0];
    assign wd = wb_i.dat[7:0];

    always_comb begin
        case (idx)
            `EIU_IDX_CTRL: rd_next = ctrl_reg;
            `EIU_IDX_EDGE: rd_next = edge_reg;
            `EIU_IDX_PEND: rd_next = pend_reg;
            `EIU_IDX_MASK: rd_next = mask_reg;
            `EIU_IDX_PAIR: rd_next = pair_reg;
            `EIU_IDX_VECT: rd_next = vect_reg;
            `EIU_IDX_HOLD: rd_next = {lock_reg, hold_reg};
            `EIU_IDX_SRC: rd_next = {src_reg[7:1], vect_reg[`EIU_VECT_A0S]};
            default: rd_next = 8'h00;
        endcase
    end

    // unmapped addresses are acked and read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= {24'h00_0000, rd_next};
        end
    end

    logic wr_ctrl, wr_pend, wr_hold;
    assign wr_ctrl = wr && idx == `EIU_IDX_CTRL;
    assign wr_pend = wr && idx == `EIU_IDX_PEND;
    assign wr_hold = wr && idx == `EIU_IDX_HOLD;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_reg <= `EIU_RST_EDGE;
            mask_reg <= 8'h00;
            pair_reg <= `EIU_RST_PAIR;
            vect_reg <= `EIU_RST_VECT;
            src_reg <= `EIU_RST_SRC;
        end else if (wr) begin
            case (idx)
                `EIU_IDX_EDGE: edge_reg <= wd;
                `EIU_IDX_MASK: mask_reg <= wd;
                `EIU_IDX_PAIR: pair_reg <= wd;
                `EIU_IDX_VECT: vect_reg <= wd;
                `EIU_IDX_SRC: src_reg <= wd;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers and source selection
    // ------------------------------------------------------------
    logic [8:0] pin_s1_reg, pin_s2_reg;
    logic [7:0] src_sel, chan_in, chan_prev_reg, chan_evt;
    logic [2:0] chan_prio [8];
    logic top_in, top_prev_reg, top_evt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= 9'h000;
            pin_s2_reg <= 9'h000;
        end else begin
            pin_s1_reg <= {nmi_pin_i, ext_pin_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign src_sel = {src_reg[7:1], vect_reg[`EIU_VECT_A0S]};

    // a missed short pulse is the source's fault: one level per clock
    generate
        for (genvar g = 0; g < 8; g++) begin : g_chan
            localparam int P = g / 2;
            assign chan_in[g] = src_sel[g] ? pin_s2_reg[g]
                                           : periph_evt_i[g];
            assign chan_evt[g] = edge_reg[g]
                ? (chan_in[g] & ~chan_prev_reg[g])
                : (~chan_in[g] & chan_prev_reg[g]);
            assign chan_prio[g] = {pair_reg[2*P+1], pair_reg[2*P],
                                   1'(g % 2)};
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    chan_prev_reg[g] <= 1'b0;
                    pend_reg[g] <= 1'b0;
                end else begin
                    chan_prev_reg[g] <= chan_in[g];
                    // set beats both software and acknowledge clear
                    if (chan_evt[g] || (wr_pend && wd[g])) begin
                        pend_reg[g] <= 1'b1;
                    end else if (wr_pend) begin
                        pend_reg[g] <= 1'b0;
                    end else if (service_start_o && !req_top_o
                                 && req_level_o == chan_prio[g]
                                 && vector_o[3:1] == 3'(g)) begin
                        pend_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // top level source
    // ------------------------------------------------------------
    assign top_in = vect_reg[`EIU_VECT_TSRC] ? pin_s2_reg[8]
                                            : wdg_eoc_i;
    assign top_evt = (vect_reg[`EIU_VECT_TSRC]
                      && !vect_reg[`EIU_VECT_POL])
        ? (~top_in & top_prev_reg)
        : (top_in & ~top_prev_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_prev_reg <= 1'b0;
            top_pend_reg <= 1'b0;
        end else begin
            top_prev_reg <= top_in;
            if (top_evt || (wr_ctrl && wd[`EIU_CTRL_TOPP])) begin
                top_pend_reg <= 1'b1;
            end else if (service_start_o && req_top_o) begin
                top_pend_reg <= 1'b0;
            end
        end
    end

    // lock can only go up; only reset brings it down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_reg <= 1'b0;
        end else if (wr_hold && wd[`EIU_HOLD_LOCK]) begin
            lock_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic gie, nested, top_req, win_valid;
    logic [2:0] current_priority_level, win_level, win_chan;
    logic cand_valid_reg, cand_top_reg;
    logic [2:0] cand_level_reg, cand_chan_reg;

    assign gie = ctrl_reg[`EIU_CTRL_GIE];
    assign nested = ctrl_reg[`EIU_CTRL_MODE];
    assign current_priority_level = ctrl_reg[2:0];
    assign top_req = top_pend_reg && (lock_reg
                     || (ctrl_reg[`EIU_CTRL_TLI] && gie));

    always_comb begin
        win_valid = 1'b0;
        win_level = `EIU_LOWEST;
        win_chan = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (mask_reg[i] && pend_reg[i] && gie
                && chan_prio[i] < win_level) begin
                win_valid = 1'b1;
                win_level = chan_prio[i];
                win_chan = 3'(i);
            end
        end
        if (win_level >= current_priority_level) begin
            win_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arb_cnt_reg <= 3'h0;
        end else if (arb_cnt_reg == 3'(`EIU_ARB_CYCLES - 1)) begin
            arb_cnt_reg <= 3'h0;
        end else begin
            arb_cnt_reg <= arb_cnt_reg + 3'h1;
        end
    end

    // sample once per window; the grant comes at its end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cand_valid_reg <= 1'b0;
            cand_top_reg <= 1'b0;
            cand_level_reg <= 3'h0;
            cand_chan_reg <= 3'h0;
        end else if (arb_cnt_reg == 3'h0) begin
            cand_valid_reg <= (top_req || win_valid)
                && state_reg == eiu_pkg::ENT_IDLE
                && !top_active_reg;
            cand_top_reg <= top_req;
            cand_level_reg <= win_level;
            cand_chan_reg <= win_chan;
        end
    end

    // ------------------------------------------------------------
    // request and entry sequence
    // ------------------------------------------------------------
    logic [4:0] ent_len;
    logic go;
    assign ent_len = 5'(`EIU_ENTRY_BASE)
        + (stack_in_rf_i ? 5'(`EIU_ENTRY_STACK) : 5'h00)
        + (csr_save_i ? 5'(`EIU_ENTRY_CSR) : 5'h00)
        + (wfi_i ? 5'(`EIU_ENTRY_WFI) : 5'h00);
    // abort if nothing written yet, else wait for the instruction end
    assign go = !write_done_i || instr_end_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= eiu_pkg::ENT_IDLE;
            req_o <= 1'b0;
            req_top_o <= 1'b0;
            req_level_o <= 3'h0;
            vector_o <= 8'h00;
            service_start_o <= 1'b0;
            abort_o <= 1'b0;
            entry_done_o <= 1'b0;
            ent_cnt_reg <= 5'h00;
        end else begin
            service_start_o <= 1'b0;
            abort_o <= 1'b0;
            entry_done_o <= 1'b0;
            case (state_reg)
                eiu_pkg::ENT_IDLE: begin
                    if (arb_cnt_reg == 3'(`EIU_ARB_CYCLES - 1)
                        && cand_valid_reg) begin
                        state_reg <= eiu_pkg::ENT_HOLD;
                        req_o <= 1'b1;
                        req_top_o <= cand_top_reg;
                        req_level_o <= cand_level_reg;
                        vector_o <= {vect_reg[7:4], cand_chan_reg, 1'b0};
                    end
                end
                eiu_pkg::ENT_HOLD: begin
                    if (go) begin
                        state_reg <= eiu_pkg::ENT_CYCLE;
                        req_o <= 1'b0;
                        service_start_o <= 1'b1;
                        abort_o <= !write_done_i;
                        ent_cnt_reg <= ent_len;
                    end
                end
                eiu_pkg::ENT_CYCLE: begin
                    ent_cnt_reg <= ent_cnt_reg - 5'h01;
                    if (ent_cnt_reg == 5'h02) begin
                        entry_done_o <= 1'b1;
                        state_reg <= eiu_pkg::ENT_IDLE;
                    end
                end
                default: state_reg <= eiu_pkg::ENT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_active_reg <= 1'b0;
        end else if (service_start_o && req_top_o) begin
            top_active_reg <= 1'b1;
        end else if (iret_i) begin
            top_active_reg <= 1'b0;
        end
    end
    assign top_isr_o = top_active_reg;

    // ------------------------------------------------------------
    // central control, enable and level stack
    // ------------------------------------------------------------
    logic ent_n, ret_n;
    logic [2:0] pop_level;
    assign ent_n = service_start_o && !req_top_o;
    assign ret_n = iret_i && !top_active_reg;

    always_comb begin
        pop_level = `EIU_LOWEST;
        for (int i = 6; i >= 0; i--) begin
            if (hold_reg[i]) begin
                pop_level = 3'(i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `EIU_RST_CTRL;
        end else begin
            ctrl_reg[`EIU_CTRL_TOPP] <= top_pend_reg;
            if (wr_ctrl) begin
                ctrl_reg[`EIU_CTRL_MFT] <= wd[`EIU_CTRL_MFT];
                ctrl_reg[`EIU_CTRL_TLI] <= wd[`EIU_CTRL_TLI];
                ctrl_reg[`EIU_CTRL_MODE] <= wd[`EIU_CTRL_MODE];
                ctrl_reg[2:0] <= wd[2:0];
            end else if (ent_n && nested) begin
                ctrl_reg[2:0] <= req_level_o;
            end else if (ret_n && nested) begin
                ctrl_reg[2:0] <= pop_level;
            end
            if (ei_i || ret_n) begin
                ctrl_reg[`EIU_CTRL_GIE] <= 1'b1;
            end else if (di_i || ent_n) begin
                ctrl_reg[`EIU_CTRL_GIE] <= 1'b0;
            end else if (wr_ctrl && (wd[`EIU_CTRL_GIE]
                         || !cand_valid_reg)) begin
                // a clear is held off while a grant is forming
                ctrl_reg[`EIU_CTRL_GIE] <= wd[`EIU_CTRL_GIE];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg <= 7'h00;
        end else if (wr_hold) begin
            hold_reg <= wd[6:0];
        end else if (ent_n && nested && current_priority_level != `EIU_LOWEST) begin
            hold_reg[current_priority_level] <= 1'b1;
        end else if (ret_n && nested && pop_level != `EIU_LOWEST) begin
            hold_reg[pop_level] <= 1'b0;
        end
    end

    assign mft_enable_o = ctrl_reg[`EIU_CTRL_MFT];
    assign wait_enable_o = vect_reg[`EIU_VECT_WAIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_plain;
        service_start_o && !stack_in_rf_i && !csr_save_i && !wfi_i;
    endsequence
    sequence s_entry_end;
        !entry_done_o [*8] ##1 !entry_done_o [*8] ##1 entry_done_o;
    endsequence

    chk_entry_length: assert property (
        s_start_plain |-> ##1 s_entry_end)
        else $error("entry length wrong");
    chk_arb_period: assert property (
        arb_cnt_reg == 3'h0 |-> ##5 arb_cnt_reg == 3'h0)
        else $error("arbitration period wrong");
    chk_level_seven: assert property (
        service_start_o && !req_top_o |-> req_level_o != 3'h7)
        else $error("level seven granted");
    chk_top_blocks: assert property (
        top_active_reg |=> !req_o || $past(req_o))
        else $error("grant during top routine");
    chk_top_keeps_state: assert property (
        service_start_o && req_top_o && !ei_i && !di_i && !wr_ctrl
        && !wr_hold |=> $stable(ctrl_reg[4:0]) && $stable(hold_reg))
        else $error("top entry changed state");
    chk_entry_clears_gie: assert property (
        service_start_o && !req_top_o && !ei_i |=> !gie)
        else $error("entry kept enable");
    chk_top_event_pend: assert property (
        top_evt |=> top_pend_reg)
        else $error("top event lost");
    chk_chan_event_pend: assert property (
        chan_evt[0] |=> pend_reg[0])
        else $error("channel event lost");
    chk_lock_sticks: assert property (
        lock_reg |=> lock_reg)
        else $error("lock cleared");
    chk_nonmask_request: assert property (
        arb_cnt_reg == 3'h0 && top_req && !top_active_reg
        && state_reg == eiu_pkg::ENT_IDLE |-> ##5 req_o && req_top_o)
        else $error("top request not raised");
    chk_abort_rule: assert property (
        req_o && write_done_i && !instr_end_i |=> !service_start_o)
        else $error("aborted after a write");
    // bounds hold for short instructions; long divides stretch the wait
    chk_top_latency: assert property (
        top_evt && lock_reg && !top_active_reg && !cand_valid_reg
        && !win_valid && state_reg == eiu_pkg::ENT_IDLE
        |-> ##[22:45] entry_done_o)
        else $error("top latency out of range");
    // channel event is seen two clocks after the pin moves
    chk_chan_latency: assert property (
        chan_evt[0] && mask_reg[0] && gie && !top_pend_reg
        && !top_active_reg && !cand_valid_reg && !win_valid
        && state_reg == eiu_pkg::ENT_IDLE && chan_prio[0] < current_priority_level
        |-> ##[24:47] entry_done_o)
        else $error("channel latency out of range");
endmodule // eiu_top

// [sim/eiu_core_model.sv]
`timescale 1ns/1ps
module eiu_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    output logic write_done_o,
    output logic instr_end_o
);
    // ----------------------------------------
    // instruction pacing
    // ----------------------------------------
    logic [2:0] step_reg;
    // fixed seven-clock instruction keeps end points predictable
    always_ff @(posedge clk_i) begin
        if (rst_i || step_reg == 3'h6) begin
            step_reg <= 3'h0;
        end else begin
            step_reg <= step_reg + 3'h1;
        end
    end
    assign instr_end_o = (step_reg == 3'h6);
    // slow mode writes early, so nothing can be aborted
    assign write_done_o = slow_i;
endmodule // eiu_core_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "eiu_map.svh"
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, nmi = 1'b1, wdg = 1'b0;
    logic ei = 1'b0, di = 1'b0, iret = 1'b0, slow = 1'b0;
    logic stk = 1'b0, csr = 1'b0, wfi = 1'b0, wdone, iend;
    logic [7:0] pin = 8'h00, per = 8'h00, vec, q;
    logic [31:0] rdat;
    logic ack, req, rtop, svc, abrt, edone, tisr, mft, wen;
    logic [2:0] lvl;
    eiu_pkg::eiu_wb_req_t wb = '0;
    int n_mismatch = 0, compares = 0;
    initial forever #4 clk_i = ~clk_i;
    eiu_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_pin_i(pin), .nmi_pin_i(nmi),
        .periph_evt_i(per), .wdg_eoc_i(wdg), .write_done_i(wdone),
        .instr_end_i(iend), .iret_i(iret), .ei_i(ei), .di_i(di),
        .stack_in_rf_i(stk), .csr_save_i(csr), .wfi_i(wfi), .req_o(req),
        .req_top_o(rtop), .req_level_o(lvl), .vector_o(vec),
        .service_start_o(svc), .abort_o(abrt), .entry_done_o(edone),
        .top_isr_o(tisr), .mft_enable_o(mft), .wait_enable_o(wen));
    eiu_core_model core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .write_done_o(wdone), .instr_end_o(iend));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] idx, d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb.cyc <= 1'b1;
        wb.stb <= 1'b1;
        wb.we <= we;
        wb.adr <= {idx, 2'b00};
        wb.sel <= 4'h1;
        wb.dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        wb <= '0;
        if (n >= 50) begin
            check("bus ack", 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] idx, d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, exp);
        bus(1'b0, idx, 8'h00);
        check("register", q, exp);
    endtask
    task automatic pulse(input logic [2:0] w);
        @(posedge clk_i);
        ei <= w[0];
        di <= w[1];
        iret <= w[2];
        @(posedge clk_i);
        {ei, di, iret} <= 3'h0;
    endtask
    task automatic quiet(input int cyc);
        logic bad;
        bad = 1'b0;
        repeat (cyc) begin
            @(posedge clk_i);
            if (req !== 1'b0 || svc !== 1'b0) bad = 1'b1;
        end
        check("quiet", bad, 1'b0);
    endtask
    // waits for entry, judges it, then times the entry cycle
    task automatic serve(input logic t, input logic [2:0] lv, ch,
        input logic ab, input int len);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (svc !== 1'b1 && n < 300);
        if (n >= 300) begin
            check("service", 1'b0, 1'b1);
            tally_and_finish();
        end
        check("top", rtop, t);
        check("abort", abrt, ab);
        if (!t) begin
            check("level", lvl, lv);
            check("channel", vec[3:1], ch);
        end
        // the service start cycle is the first clock of the entry
        n = 1;
        do begin
            @(posedge clk_i);
            n++;
        end while (edone !== 1'b1 && n < 60);
        check("entry length", n, len);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        check("mft", mft, 1'b1);
        check("wait enable", wen, 1'b0);
        wr(`EIU_IDX_VECT, 8'h07);
        check("wait enable", wen, 1'b1);
        wr(`EIU_IDX_VECT, 8'h06);
        rd(`EIU_IDX_CTRL, 8'h87);
        rd(`EIU_IDX_EDGE, 8'h00);
        rd(`EIU_IDX_PAIR, 8'hFF);
        rd(8'h10, 8'h00);
        wr(`EIU_IDX_EDGE, 8'h5A);
        rd(`EIU_IDX_EDGE, 8'h5A);
        $display("test regs done");
    endtask
    task automatic t_chan();
        wr(`EIU_IDX_PAIR, 8'h3F);
        wr(`EIU_IDX_EDGE, 8'h01);
        pin[0] <= 1'b1;
        repeat (5) @(posedge clk_i);
        rd(`EIU_IDX_PEND, 8'h01);
        wr(`EIU_IDX_PEND, 8'h41);
        wr(`EIU_IDX_MASK, 8'h41);
        pulse(3'b001);
        serve(1'b0, 3'h0, 3'h6, 1'b1, 18);
        rd(`EIU_IDX_CTRL, 8'h87);
        rd(`EIU_IDX_PEND, 8'h01);
        pulse(3'b100);
        serve(1'b0, 3'h6, 3'h0, 1'b1, 18);
        pulse(3'b100);
        rd(`EIU_IDX_CTRL, 8'h97);
        $display("test channel done");
    endtask
    task automatic t_mask();
        wr(`EIU_IDX_MASK, 8'h02);
        wr(`EIU_IDX_PEND, 8'h03);
        quiet(40);
        wr(`EIU_IDX_PEND, 8'h00);
        rd(`EIU_IDX_PEND, 8'h00);
        wr(`EIU_IDX_MASK, 8'h01);
        $display("test mask done");
    endtask
    task automatic t_top();
        pulse(3'b010);
        wr(`EIU_IDX_CTRL, 8'hA7);
        nmi <= 1'b0;
        quiet(30);
        rd(`EIU_IDX_CTRL, 8'hE7);
        wr(`EIU_IDX_HOLD, 8'h80);
        serve(1'b1, 3'h0, 3'h0, 1'b1, 18);
        check("top busy", tisr, 1'b1);
        rd(`EIU_IDX_CTRL, 8'hA7);
        wr(`EIU_IDX_PEND, 8'h01);
        pulse(3'b001);
        quiet(30);
        pulse(3'b100);
        serve(1'b0, 3'h6, 3'h0, 1'b1, 18);
        pulse(3'b100);
        wr(`EIU_IDX_HOLD, 8'h00);
        rd(`EIU_IDX_HOLD, 8'h80);
        wr(`EIU_IDX_VECT, 8'h0E);
        nmi <= 1'b1;
        serve(1'b1, 3'h0, 3'h0, 1'b1, 18);
        pulse(3'b100);
        wr(`EIU_IDX_VECT, 8'h0A);
        @(posedge clk_i);
        wdg <= 1'b1;
        @(posedge clk_i);
        wdg <= 1'b0;
        serve(1'b1, 3'h0, 3'h0, 1'b1, 18);
        pulse(3'b100);
        rd(`EIU_IDX_CTRL, 8'hB7);
        $display("test top done");
    endtask
    task automatic t_source();
        wr(`EIU_IDX_MASK, 8'h00);
        wr(`EIU_IDX_EDGE, 8'h02);
        wr(`EIU_IDX_SRC, 8'hFD);
        pin[1] <= 1'b1;
        repeat (5) @(posedge clk_i);
        rd(`EIU_IDX_PEND, 8'h00);
        per[1] <= 1'b1;
        repeat (5) @(posedge clk_i);
        rd(`EIU_IDX_PEND, 8'h02);
        wr(`EIU_IDX_PEND, 8'h00);
        wr(`EIU_IDX_MASK, 8'h01);
        pin[0] <= 1'b0;
        serve(1'b0, 3'h6, 3'h0, 1'b1, 18);
        pulse(3'b100);
        $display("test source done");
    endtask
    task automatic t_slow();
        slow <= 1'b1;
        {stk, csr, wfi} <= 3'h7;
        wr(`EIU_IDX_CTRL, 8'hBF);
        wr(`EIU_IDX_PEND, 8'h01);
        wr(`EIU_IDX_MASK, 8'h41);
        serve(1'b0, 3'h6, 3'h0, 1'b0, 23);
        rd(`EIU_IDX_CTRL, 8'hAE);
        wr(`EIU_IDX_PEND, 8'h40);
        pulse(3'b001);
        serve(1'b0, 3'h0, 3'h6, 1'b0, 23);
        rd(`EIU_IDX_HOLD, 8'hC0);
        pulse(3'b100);
        rd(`EIU_IDX_CTRL, 8'hBE);
        pulse(3'b100);
        rd(`EIU_IDX_CTRL, 8'hBF);
        slow <= 1'b0;
        $display("test slow done");
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_chan();
        t_mask();
        t_top();
        t_source();
        t_slow();
        tally_and_finish();
    end
endmodule // tb_top
